// ===== logic/qhp_host_port.sv
// Host bus port of a four-channel UART: decodes both bus styles into register accesses.
//
// Functional notes
// RULE1: strap high strobes, strap low read/write line.
// RULE2: three address bits pick the channel register.
// RULE3: eight-bit data bus, device drives on reads.
// RULE4: read strobe fall reads, byte driven until rise.
// RULE5: write strobe fall starts, rise loads data byte.
// RULE6: read/write-line style ignores the read strobe.
// RULE7: direction line high reads, low writes.
// RULE8: strobe style answers only the selected channel.
// RULE9: channel A select qualifies every read/write-line access.
// RULE10: channel B select is address bit three.
// RULE11: channel C select is address bit four.
// RULE12: channel D select ignored in read/write-line style.
// RULE13: address bits four, three map channels A-D.
// RULE14: data bus driven only during qualified reads.
`timescale 1ns/1ps
`include "qhp_map.svh"
module qhp_host_port
    import qhp_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   busStyleStrap,
    input  wire logic [`QHP_ADDR_W-1:0] regAddrPin,
    input  wire logic [`QHP_DATA_W-1:0] dataIn,
    output logic      [`QHP_DATA_W-1:0] dataOut_q,
    output logic                        dataOe_q,
    input  wire logic                   read_strobe_n,
    input  wire logic                   write_strobe_n,
    input  wire logic                   chan_a_select_n,
    input  wire logic                   chan_b_select_n,
    input  wire logic                   chan_c_select_n,
    input  wire logic                   chan_d_select_n,
    output logic                        busStyle_q,
    output logic                        portReady_q,
    output logic                        regRdStb_q,
    output logic                        regWrStb_q,
    output qhp_chan_t                   regChan_q,
    output logic      [`QHP_ADDR_W-1:0] regAddr_q,
    output logic      [`QHP_DATA_W-1:0] regWrData_q,
    input  wire logic [`QHP_DATA_W-1:0] regRdData
);

    // Lowest-numbered asserted active-low select wins when several are low.
    function automatic qhp_chan_t selToChan(input logic [`QHP_SEL_W-1:0] selN);
        qhp_chan_t c;
        c = `QHP_CHAN_A;
        if (!selN[`QHP_SEL_A]) begin
            c = `QHP_CHAN_A;
        end else if (!selN[`QHP_SEL_B]) begin
            c = `QHP_CHAN_B;
        end else if (!selN[`QHP_SEL_C]) begin
            c = `QHP_CHAN_C;
        end else begin
            c = `QHP_CHAN_D;
        end
        return c;
    endfunction

    logic [`QHP_PIN_W-1:0]  pinRaw;
    logic [`QHP_PIN_W-1:0]  pinSync;
    logic                   strapS;
    logic                   rdNS;
    logic                   wrNS;
    logic [`QHP_SEL_W-1:0]  selNS;
    logic [`QHP_ADDR_W-1:0] addrS;
    logic [`QHP_DATA_W-1:0] dataS;

    // Every pin input crosses into the clock domain before use.
    assign pinRaw = {busStyleStrap, read_strobe_n, write_strobe_n,
                     chan_d_select_n, chan_c_select_n, chan_b_select_n,
                     chan_a_select_n, regAddrPin, dataIn};

    qhp_sync #(
        .W         (`QHP_PIN_W),
        .RESET_VAL (`QHP_PIN_RST)
    ) pinSyncInst (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (pinRaw),
        .syncOut (pinSync)
    );

    // Split the synchronised bundle back into named pins.
    assign {strapS, rdNS, wrNS, selNS, addrS, dataS} = pinSync;

    logic [1:0] settle_q;
    logic       settled;

    // Hold off until the synchroniser carries real pin levels, then catch the strap once.
    assign settled = (settle_q == `QHP_SETTLE_CNT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_q    <= 2'h0;
            busStyle_q  <= `QHP_STYLE_STROBE;
            portReady_q <= 1'b0;
        end else if (!settled) begin
            settle_q <= settle_q + 2'h1;
        end else if (!portReady_q) begin
            busStyle_q  <= strapS; // RULE1
            portReady_q <= 1'b1;
        end
    end

    logic      styleStrobe;
    logic      anySelect;
    logic      strobeRdAct;
    logic      strobeWrAct;
    logic      rwSelect;
    logic      rwDirRead;
    logic      rdActive;
    logic      wrActive;
    qhp_chan_t accChan;

    // Strobe style: a channel's own select qualifies the strobes.
    assign styleStrobe = (busStyle_q == `QHP_STYLE_STROBE); // RULE1
    assign anySelect   = ~&selNS; // RULE8
    assign strobeRdAct = anySelect && !rdNS && wrNS;
    assign strobeWrAct = anySelect && !wrNS && rdNS;

    // Read/write-line style: one select, the write strobe pin as direction.
    assign rwSelect  = !selNS[`QHP_SEL_A]; // RULE9
    assign rwDirRead = wrNS; // RULE7 RULE6 RULE12

    // Qualified access of either style; nothing counts before the strap is caught.
    assign rdActive = portReady_q && (styleStrobe ? strobeRdAct : (rwSelect && rwDirRead));
    assign wrActive = portReady_q && (styleStrobe ? strobeWrAct : (rwSelect && !rwDirRead));

    // Target channel: select decode or the two upper address bits.
    assign accChan = styleStrobe ? selToChan(selNS) // RULE8
                   : {selNS[`QHP_SEL_C], selNS[`QHP_SEL_B]}; // RULE10 RULE11 RULE13

    qhp_state_e             state_q;
    qhp_state_e             state_d;
    logic [`QHP_DATA_W-1:0] wrHold_q;

    // Sequencer: idle, request read, drive read data, collect write data.
    always_comb begin
        state_d = state_q;
        case (state_q)
            QHP_IDLE: begin
                if (rdActive) begin
                    state_d = QHP_RD_REQ; // RULE4
                end else if (wrActive) begin
                    state_d = QHP_WR_ACC; // RULE5
                end
            end
            QHP_RD_REQ: begin
                state_d = QHP_RD_DRV;
            end
            QHP_RD_DRV: begin
                if (!rdActive) begin
                    state_d = QHP_IDLE; // RULE4
                end
            end
            QHP_WR_ACC: begin
                if (!wrActive) begin
                    state_d = QHP_IDLE; // RULE5
                end
            end
            default: begin
                state_d = QHP_IDLE;
            end
        endcase
    end

    logic startAcc;
    logic wrDone;
    logic rdEnd;

    // Events that the register side sees.
    assign startAcc = (state_q == QHP_IDLE) && (rdActive || wrActive);
    assign wrDone   = (state_q == QHP_WR_ACC) && !wrActive;
    assign rdEnd    = (state_q == QHP_RD_DRV) && !rdActive;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= QHP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Channel and register address are caught when the access opens.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regChan_q <= `QHP_CHAN_A;
            regAddr_q <= '0;
        end else if (startAcc) begin
            regChan_q <= accChan;
            regAddr_q <= addrS; // RULE2
        end
    end

    // One-cycle read request as the read access opens.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdStb_q <= 1'b0;
        end else begin
            regRdStb_q <= (state_q == QHP_IDLE) && rdActive; // RULE4
        end
    end

    // Track the bus byte during the write; the last value before release is loaded.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrHold_q <= '0;
        end else if (wrActive) begin
            wrHold_q <= dataS; // RULE3
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regWrStb_q  <= 1'b0;
            regWrData_q <= '0;
        end else begin
            regWrStb_q <= wrDone; // RULE5
            if (wrDone) begin
                regWrData_q <= wrHold_q;
            end
        end
    end

    // Read data is captured once and driven until the access ends.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataOut_q <= '0;
            dataOe_q  <= 1'b0;
        end else if (state_q == QHP_RD_REQ) begin
            dataOut_q <= regRdData; // RULE3
            dataOe_q  <= rdActive; // RULE14
        end else if (rdEnd || state_q != QHP_RD_DRV) begin
            dataOe_q <= 1'b0; // RULE14
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Opening of a read in each style.
    sequence s_rd_open;
        (state_q == QHP_IDLE) && rdActive;
    endsequence

    sequence s_rd_serve;
        regRdStb_q && (state_q == QHP_RD_REQ) ##1 !regRdStb_q && (state_q == QHP_RD_DRV);
    endsequence

    a_strap_held_fixed: assert property (portReady_q |=> $stable(busStyle_q)) // RULE1
        else $error("Bus style changed after the strap was caught.");

    a_addr_caught_open: assert property (s_rd_open |=> regAddr_q == $past(addrS)) // RULE2
        else $error("Register address not taken from the pins at read start.");

    a_read_request: assert property (s_rd_open |=> s_rd_serve) // RULE4
        else $error("Read opening did not raise one read request.");

    a_read_data_out: assert property (
        regRdStb_q && rdActive ##1 rdActive |=> dataOe_q && dataOut_q == $past(regRdData, 2)) // RULE3
        else $error("Read byte not driven after the request.");

    a_bus_only_read: assert property (
        dataOe_q |-> (state_q == QHP_RD_DRV) || $past(state_q == QHP_RD_DRV)) // RULE14
        else $error("Data bus driven outside a read access.");

    a_write_at_release: assert property (
        wrDone |=> regWrStb_q && regWrData_q == $past(wrHold_q)) // RULE5
        else $error("Write not loaded when the write access ended.");

    a_rw_no_rdstrobe: assert property (
        !styleStrobe && portReady_q && !rdNS && wrNS && !rwSelect && state_q == QHP_IDLE
        |=> !regRdStb_q) // RULE6
        else $error("Read strobe acted in read/write-line style.");

    a_rw_direction_low: assert property (
        !styleStrobe && portReady_q && rwSelect && !wrNS && state_q == QHP_IDLE
        |=> state_q == QHP_WR_ACC && !regRdStb_q) // RULE7
        else $error("Direction low did not open a write.");

    a_strobe_own_chan: assert property (
        styleStrobe && regRdStb_q |-> (($past(selNS) >> regChan_q) & 4'h1) == 4'h0) // RULE8
        else $error("Read served a channel whose select was high.");

    a_rw_chan_decode: assert property (
        !styleStrobe && regRdStb_q |->
        regChan_q == $past({selNS[`QHP_SEL_C], selNS[`QHP_SEL_B]})) // RULE13
        else $error("Channel not decoded from address bits four and three.");

    // Pin patterns that are no access must leave the sequencer idle.
    a_idle_before_ready: assert property (!portReady_q |=> !regRdStb_q && !regWrStb_q) // RULE1
        else $error("Register request raised before the strap was caught.");

    a_strobe_both_low: assert property (
        styleStrobe && portReady_q && !rdNS && !wrNS && state_q == QHP_IDLE
        |=> state_q == QHP_IDLE && !regRdStb_q) // RULE5
        else $error("Both strobes low opened an access.");

    a_rw_needs_select: assert property (
        !styleStrobe && !rwSelect && state_q == QHP_IDLE |=> state_q == QHP_IDLE) // RULE9
        else $error("Access opened without the chip select in read/write-line style.");

endmodule

// ===== logic/qhp_map.svh
// Constants for the quad UART host bus port: widths, codes and counts.
`ifndef QHP_MAP_SVH
`define QHP_MAP_SVH

// Bus widths.
`define QHP_ADDR_W      3
`define QHP_DATA_W      8
`define QHP_CHAN_W      2
`define QHP_SEL_W       4

// Strap level that picks the separate-strobe bus style.
`define QHP_STYLE_STROBE 1'b1

// Channel codes on the internal register side.
`define QHP_CHAN_A      2'h0
`define QHP_CHAN_B      2'h1
`define QHP_CHAN_C      2'h2
`define QHP_CHAN_D      2'h3

// Positions of the select inputs within the select group.
`define QHP_SEL_A       0
`define QHP_SEL_B       1
`define QHP_SEL_C       2
`define QHP_SEL_D       3

// Width of the bundle of pin inputs that pass the synchroniser.
`define QHP_PIN_W       18

// Reset level of the synchronised pins: strobes, selects and strap idle high.
`define QHP_PIN_RST     18'h3f800

// Edges after reset release before the synchronised strap is trusted.
`define QHP_SETTLE_CNT  2'h3

`endif

// ===== logic/qhp_pkg.sv
// Types shared by the quad UART host bus port.
package qhp_pkg;

    // Access sequencer states, one-hot.
    typedef enum logic [3:0] {
        QHP_IDLE   = 4'b0001,
        QHP_RD_REQ = 4'b0010,
        QHP_RD_DRV = 4'b0100,
        QHP_WR_ACC = 4'b1000
    } qhp_state_e;

    // Channel index on the internal register side.
    typedef logic [1:0] qhp_chan_t;

endpackage

// ===== logic/qhp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin inputs.
`timescale 1ns/1ps
module qhp_sync #(
    parameter int                W         = 1,
    parameter logic [W-1:0]      RESET_VAL = '0
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [W-1:0]    pinIn,
    output logic      [W-1:0]    syncOut
);

    logic [W-1:0] stage1_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_q <= RESET_VAL;
            syncOut  <= RESET_VAL;
        end else begin
            stage1_q <= pinIn;
            syncOut  <= stage1_q;
        end
    end

endmodule

// ===== sim/qhp_host_model.sv
// Host processor model that drives the pin side of the host bus port.
`timescale 1ns/1ps
module qhp_host_model (
    input  wire logic       clk,
    input  wire logic       dataOe,
    input  wire logic [7:0] dataOut,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic [3:0]      selN,
    output logic [2:0]      regAddrPin,
    output logic [7:0]      hostData,
    output logic            hostOe
);
    // Pins start idle so nothing looks like an access before the port is ready.
    initial begin
        {read_strobe_n, write_strobe_n, selN, regAddrPin, hostData, hostOe} = 18'h3f000;
    end

    // Releases strobes, selects and the data bus.
    task automatic idle();
        {read_strobe_n, write_strobe_n, selN, hostOe} = 7'h7e;
    endtask

    // One whole access; a read holds until the device drives the bus, then takes the byte.
    task automatic access(input logic strobeStyle, input logic isWrite, input logic [1:0] chan,
                          input logic [2:0] addr, input logic [7:0] wData,
                          output logic [7:0] rData, output logic oeSeen, output int lat);
        @(posedge clk);
        #1;
        regAddrPin = addr;
        hostData = wData;
        hostOe = isWrite;
        write_strobe_n = !isWrite;
        if (strobeStyle) begin
            read_strobe_n = isWrite;
            selN = ~(4'h1 << chan);
        end else begin
            read_strobe_n = 1'b0;
            selN = {1'b0, chan, 1'b0};
        end
        oeSeen = 1'b0;
        rData = 8'h00;
        lat = 0;
        while (lat < 10 && !(isWrite ? lat >= 4 : oeSeen)) begin
            @(posedge clk);
            #1;
            lat++;
            if (dataOe) begin
                oeSeen = 1'b1;
                rData = dataOut;
            end
        end
        idle();
        repeat (5) @(posedge clk);
    endtask

    // Holds a raw pin pattern {read, write, selects} for a while, then goes idle.
    task automatic raw(input logic [5:0] pins, output logic oeSeen);
        @(posedge clk);
        #1;
        {read_strobe_n, write_strobe_n, selN} = pins;
        oeSeen = 1'b0;
        repeat (7) begin
            @(posedge clk);
            oeSeen |= dataOe;
        end
        #1;
        idle();
        repeat (5) @(posedge clk);
    endtask
endmodule

// ===== sim/qhp_host_port_tb_top.sv
// Self-checking testbench of the host bus port in both bus styles.
`timescale 1ns/1ps
`include "qhp_map.svh"
module qhp_host_port_tb_top;
    import qhp_pkg::*;

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            strap = 1'b1;
    logic [7:0]      dataIn, dataOut_q, hostData, regWrData_q, floatBus = 8'h3c;
    logic            dataOe_q, hostOe, busStyle_q, portReady_q, regRdStb_q, regWrStb_q;
    logic            readN, writeN;
    logic [3:0]      selN;
    logic [2:0]      addrPin, regAddr_q, lastAddr;
    qhp_chan_t       regChan_q, lastChan;
    logic [7:0]      lastData;
    logic [7:0]      regs [4][8];
    int              failCount = 0, samplesChecked = 0, wrCount = 0, rdCount = 0, cycles = 0;

    // Clock at 250 MHz and a released bus that changes every cycle.
    always #2 clk = ~clk;
    always @(posedge clk) floatBus <= ~floatBus;
    logic [7:0] regRdData;
    assign dataIn = dataOe_q ? dataOut_q : (hostOe ? hostData : floatBus);
    assign regRdData = regs[regChan_q][regAddr_q];

    qhp_host_port u_dut (.clk(clk), .rst(rst), .busStyleStrap(strap), .regAddrPin(addrPin),
        .dataIn(dataIn), .dataOut_q(dataOut_q), .dataOe_q(dataOe_q), .read_strobe_n(readN),
        .write_strobe_n(writeN), .chan_a_select_n(selN[0]), .chan_b_select_n(selN[1]),
        .chan_c_select_n(selN[2]), .chan_d_select_n(selN[3]), .busStyle_q(busStyle_q),
        .portReady_q(portReady_q), .regRdStb_q(regRdStb_q), .regWrStb_q(regWrStb_q),
        .regChan_q(regChan_q), .regAddr_q(regAddr_q), .regWrData_q(regWrData_q),
        .regRdData(regRdData));

    qhp_host_model u_host (.clk(clk), .dataOe(dataOe_q), .dataOut(dataOut_q),
        .read_strobe_n(readN), .write_strobe_n(writeN), .selN(selN), .regAddrPin(addrPin),
        .hostData(hostData), .hostOe(hostOe));

    // Channel register file and a record of the last request that reached it.
    initial foreach (regs[c, a]) regs[c][a] = 8'h00;
    always @(posedge clk) begin
        if (regWrStb_q) begin
            regs[regChan_q][regAddr_q] <= regWrData_q;
            lastData <= regWrData_q;
            wrCount++;
        end
        if (regRdStb_q) rdCount++;
        if (regWrStb_q || regRdStb_q) {lastChan, lastAddr} <= {regChan_q, regAddr_q};
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // A hung run counts as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            stop_test();
        end
    end

    // Resets with the given strap level and checks the caught style.
    task automatic t_reset(input logic style);
        int n;
        #1 rst = 1'b1;
        strap = style;
        repeat (3) @(posedge clk);
        check(8'(dataOe_q), 8'h00);
        #1 rst = 1'b0;
        for (n = 0; n < 10 && portReady_q !== 1'b1; n++) @(posedge clk);
        check(8'(busStyle_q), 8'(style));
    endtask

    // Writes every channel, then reads every channel back.
    task automatic t_traffic(input logic style);
        logic [7:0] rd, wd;
        logic       oe;
        int         lat, w0;
        for (int c = 0; c < 4; c++) begin
            wd = 8'h80 | 8'(c << 4) | 8'(7 - 2 * c) | (8'(style) << 6);
            w0 = wrCount;
            u_host.access(style, 1'b1, 2'(c), 3'(7 - 2 * c), wd, rd, oe, lat);
            check(8'(oe), 8'h00);
            check(8'(wrCount - w0), 8'h01);
            check(8'(lastChan), 8'(c));
            check(8'(lastAddr), 8'(7 - 2 * c));
            check(lastData, wd);
        end
        for (int c = 3; c >= 0; c--) begin
            wd = 8'h80 | 8'(c << 4) | 8'(7 - 2 * c) | (8'(style) << 6);
            w0 = rdCount;
            u_host.access(style, 1'b0, 2'(c), 3'(7 - 2 * c), 8'h00, rd, oe, lat);
            check(8'(oe), 8'h01);
            check(8'(lat), 8'h04);
            check(rd, wd);
            check(8'(rdCount - w0), 8'h01);
            check(8'(dataOe_q), 8'h00);
        end
    endtask

    // Pin patterns that are no access in the current style.
    task automatic t_refused(input logic [5:0] pins);
        logic oe;
        int   w0, r0;
        w0 = wrCount;
        r0 = rdCount;
        u_host.raw(pins, oe);
        check(8'(oe), 8'h00);
        check(8'(wrCount - w0 + rdCount - r0), 8'h00);
    endtask

    initial begin
        t_reset(`QHP_STYLE_STROBE);
        t_traffic(1'b1);
        t_refused(6'h0e);
        t_refused(6'h1f);
        t_reset(~`QHP_STYLE_STROBE);
        t_traffic(1'b0);
        t_refused(6'h01);
        t_refused(6'h17);
        stop_test();
    end
endmodule
